// ===== core/ipfc_pkg.sv
// package: register map, field positions and carrier types of the irq block
package ipfc_pkg;
	localparam int IPFC_NPINS = 20;
	localparam int IPFC_NSRC = 15;
	localparam int IPFC_NEV = 6;

	// byte offsets on the wishbone bus
	localparam logic [7:0] IPFC_OFS_TIMER_PIN_CONTROL = 8'h88;
	localparam logic [7:0] IPFC_OFS_CORE_PRIORITY = 8'hB8;
	localparam logic [7:0] IPFC_OFS_EXTENDED_PRIORITY = 8'hF8;
	localparam logic [7:0] IPFC_OFS_EXTENDED_FLAGS = 8'hE0;
	localparam logic [7:0] IPFC_OFS_EV_STATUS = 8'hC0;
	localparam logic [7:0] IPFC_OFS_EV_CLEAR = 8'hC4;
	localparam logic [7:0] IPFC_OFS_EV_ENABLE = 8'hC8;
	localparam logic [7:0] IPFC_OFS_PIN_ENABLE = 8'hD0;
	localparam logic [7:0] IPFC_OFS_PIN_LINE_SEL = 8'hD4;
	localparam logic [7:0] IPFC_OFS_PIN_RISE_EN = 8'hD8;
	localparam logic [7:0] IPFC_OFS_PIN_FALL_EN = 8'hDC;

	// values after reset
	localparam logic [7:0] IPFC_RST_BYTE = 8'h00;
	localparam logic [19:0] IPFC_RST_PIN = 20'h00000;

	// timer_pin_control fields
	localparam int IPFC_TPC_T1_OVF = 7;
	localparam int IPFC_TPC_T1_RUN = 6;
	localparam int IPFC_TPC_T0_OVF = 5;
	localparam int IPFC_TPC_T0_RUN = 4;
	localparam int IPFC_TPC_PB_FLAG = 3;
	localparam int IPFC_TPC_PB_TRIG = 2;
	localparam int IPFC_TPC_PA_FLAG = 1;
	localparam int IPFC_TPC_PA_TRIG = 0;
	localparam logic [7:0] IPFC_TPC_FLAG_MASK = 8'hAA;

	// extended_flags: held i2c master bit position and mask of the bits mirrored live from the peripherals
	localparam int IPFC_EXF_I2CM = 0;
	localparam logic [7:0] IPFC_EXF_LIVE_MASK = 8'hEE;

	// event status bit positions
	localparam int IPFC_EV_PIN_A = 0;
	localparam int IPFC_EV_PIN_B = 1;
	localparam int IPFC_EV_TMR0 = 2;
	localparam int IPFC_EV_TMR1 = 3;
	localparam int IPFC_EV_I2CM = 4;
	localparam int IPFC_EV_WAKE = 5;

	// natural-order source numbers of the two timers
	localparam logic [3:0] IPFC_SRC_TIMER0 = 4'h1;
	localparam logic [3:0] IPFC_SRC_TIMER1 = 4'h3;

	typedef struct packed {
		logic [IPFC_NPINS-1:0] enable;
		logic [IPFC_NPINS-1:0] line_b_sel;
		logic [IPFC_NPINS-1:0] rise_en;
		logic [IPFC_NPINS-1:0] fall_en;
	} ipfc_pin_cfg_t;

	typedef struct packed {
		logic line_a;
		logic line_b;
		logic wake;
	} ipfc_pin_evt_t;

	typedef struct packed {
		logic valid;
		logic high;
		logic [3:0] src;
	} ipfc_grant_t;
endpackage

// ===== core/ipfc_pin_edge.sv
// gpio synchroniser and edge detector feeding pin lines a and b
`timescale 1ns/10ps
`default_nettype none
module ipfc_pin_edge import ipfc_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [IPFC_NPINS-1:0] pins,
	input wire ipfc_pin_cfg_t cfg,
	output var ipfc_pin_evt_t evt
);
	typedef struct packed {
		logic [IPFC_NPINS-1:0] meta;
		logic [IPFC_NPINS-1:0] sync;
		logic [IPFC_NPINS-1:0] prev;
		logic [1:0] warm;
		ipfc_pin_evt_t evt;
	} ipfc_edge_st_t;

	ipfc_edge_st_t state_ff;
	ipfc_edge_st_t nxt_state;
	logic [IPFC_NPINS-1:0] hit;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.meta = pins;
		// meta stage feeds only the sync stage
		nxt_state.sync = state_ff.meta;
		nxt_state.prev = state_ff.sync;
		// no edges until prev holds a real level, else idle-high pins fire
		if (!(&state_ff.warm)) begin
			nxt_state.warm = state_ff.warm + 2'h1;
		end
		hit = {IPFC_NPINS{&state_ff.warm}} & cfg.enable &
			((cfg.rise_en & state_ff.sync & ~state_ff.prev) |
			(cfg.fall_en & ~state_ff.sync & state_ff.prev));
		nxt_state.evt.line_a = |(hit & ~cfg.line_b_sel);
		nxt_state.evt.line_b = |(hit & cfg.line_b_sel);
		nxt_state.evt.wake = |hit;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign evt = state_ff.evt;
endmodule // ipfc_pin_edge
`default_nettype wire

// ===== core/ipfc_prio_resolve.sv
// two-level priority resolver over the fifteen sources
`timescale 1ns/10ps
`default_nettype none
module ipfc_prio_resolve import ipfc_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [IPFC_NSRC-1:0] req,
	input wire logic [IPFC_NSRC-1:0] prio,
	output var ipfc_grant_t grant
);
	typedef struct packed {
		ipfc_grant_t grant;
	} ipfc_res_st_t;

	ipfc_res_st_t state_ff;
	ipfc_res_st_t nxt_state;
	logic hi_any;
	logic lo_any;
	logic [3:0] hi_src;
	logic [3:0] lo_src;

	always_comb begin
		hi_any = 1'b0;
		lo_any = 1'b0;
		hi_src = 4'h0;
		lo_src = 4'h0;
		// walk downward so the lowest natural number wins
		for (int i = IPFC_NSRC - 1; i >= 0; i--) begin
			if (req[i] && prio[i]) begin
				hi_any = 1'b1;
				hi_src = 4'(i);
			end
			if (req[i] && !prio[i]) begin
				lo_any = 1'b1;
				lo_src = 4'(i);
			end
		end
		nxt_state = state_ff;
		nxt_state.grant.valid = hi_any | lo_any;
		nxt_state.grant.high = hi_any;
		nxt_state.grant.src = hi_any ? hi_src : lo_src;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign grant = state_ff.grant;
endmodule // ipfc_prio_resolve
`default_nettype wire

// ===== core/ipfc_irq_ctrl.sv
// interrupt priority, flag and pin trigger control with wishbone registers
`timescale 1ns/10ps
`default_nettype none
// Operation
// - core priority bits per internal source
// - extended priority bits per peripheral group
// - priority one means high level
// - high level always before low level
// - extended flag register bit layout
// - only i2c master flag is writable
// - peripheral flags in bits 7..5 and 3..1 mirrored live, bit 4 reads zero
// - each pin routes to line a or b
// - rising, falling or both edges, also wake
// - timer1 overflow cleared on service entry
// - timer0 overflow cleared on service entry
// - timer1 runs while its run bit set
// - timer0 runs while its run bit set
// - pin line b flag set by hardware
// - pin line a flag set by hardware
// - line a trigger select, keep zero
module ipfc_irq_ctrl import ipfc_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [IPFC_NPINS-1:0] GPIO_I,
	input wire logic TIMER0_OVF_I,
	input wire logic TIMER1_OVF_I,
	input wire logic I2CM_EVT_I,
	input wire logic [2:0] CORE_FLAG_I,
	input wire logic [7:0] EXT_FLAG_I,
	input wire logic IRQ_ENTER_I,
	input wire logic [3:0] IRQ_ENTER_SRC_I,
	output logic TIMER0_RUN_O,
	output logic TIMER1_RUN_O,
	output logic WAKE_O,
	output logic SVC_VALID_O,
	output logic SVC_HIGH_O,
	output logic [3:0] SVC_SRC_O,
	output logic IRQ_O
);
	typedef struct packed {
		logic [7:0] tpc;
		logic [6:0] core_prio;
		logic [7:0] ext_prio;
		logic i2cm_flag;
		logic [IPFC_NEV-1:0] ev_status;
		logic [IPFC_NEV-1:0] ev_enable;
		ipfc_pin_cfg_t pin_cfg;
		logic pa_prev;
		logic pb_prev;
		logic ack;
		logic [31:0] rdata;
		logic irq;
	} ipfc_main_st_t;

	ipfc_main_st_t state_ff;
	ipfc_main_st_t nxt_state;
	ipfc_pin_evt_t pin_evt;
	ipfc_grant_t grant;
	logic [IPFC_NSRC-1:0] req_vec;
	logic [IPFC_NSRC-1:0] prio_vec;
	logic bus_req;
	logic wr_now;
	logic lane0;
	logic [7:0] wd;
	logic pa_set;
	logic pb_set;
	logic [IPFC_NEV-1:0] ev_set;
	logic [IPFC_NEV-1:0] ev_clr;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		return adr[7:2] == ofs[7:2];
	endfunction

	function automatic logic [IPFC_NPINS-1:0] merge20(
		input logic [IPFC_NPINS-1:0] old,
		input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = {12'h000, old};
		for (int b = 0; b < 3; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res[IPFC_NPINS-1:0];
	endfunction

	ipfc_pin_edge u_pin_edge (
		.clk(CLK_SYS),
		.resetn(RESETN),
		.pins(GPIO_I),
		.cfg(state_ff.pin_cfg),
		.evt(pin_evt)
	);

	// source vector in natural order, lowest index first
	assign req_vec = {EXT_FLAG_I[7:1], state_ff.i2cm_flag, CORE_FLAG_I,
		state_ff.tpc[IPFC_TPC_T1_OVF], state_ff.tpc[IPFC_TPC_PB_FLAG],
		state_ff.tpc[IPFC_TPC_T0_OVF], state_ff.tpc[IPFC_TPC_PA_FLAG]};
	// core bits map to sources 0..6
	// extended bits map to sources 7..14
	assign prio_vec = {state_ff.ext_prio, state_ff.core_prio};

	ipfc_prio_resolve u_prio (
		.clk(CLK_SYS),
		.resetn(RESETN),
		.req(req_vec),
		.prio(prio_vec),
		.grant(grant)
	);

	always_comb begin
		nxt_state = state_ff;
		bus_req = WB_CYC_I & WB_STB_I;
		// writes land on the edge that also closes the ack cycle
		wr_now = bus_req & WB_WE_I & state_ff.ack;
		lane0 = WB_SEL_I[0];
		wd = WB_DAT_I[7:0];
		nxt_state.ack = bus_req & ~state_ff.ack;
		ev_clr = '0;

		if (wr_now && lane0) begin
			if (hit(WB_ADR_I, IPFC_OFS_TIMER_PIN_CONTROL)) begin
				nxt_state.tpc = (wd & ~IPFC_TPC_FLAG_MASK) |
					(state_ff.tpc & wd & IPFC_TPC_FLAG_MASK);
			end
			if (hit(WB_ADR_I, IPFC_OFS_CORE_PRIORITY)) begin
				nxt_state.core_prio = wd[6:0];
			end
			if (hit(WB_ADR_I, IPFC_OFS_EXTENDED_PRIORITY)) begin
				nxt_state.ext_prio = wd;
			end
			// only bit 0 reacts, and only by clearing
			if (hit(WB_ADR_I, IPFC_OFS_EXTENDED_FLAGS)) begin
				nxt_state.i2cm_flag = state_ff.i2cm_flag & wd[IPFC_EXF_I2CM];
			end
			if (hit(WB_ADR_I, IPFC_OFS_EV_CLEAR)) begin
				ev_clr = wd[IPFC_NEV-1:0];
			end
			if (hit(WB_ADR_I, IPFC_OFS_EV_ENABLE)) begin
				nxt_state.ev_enable = wd[IPFC_NEV-1:0];
			end
		end
		if (wr_now) begin
			if (hit(WB_ADR_I, IPFC_OFS_PIN_ENABLE)) begin
				nxt_state.pin_cfg.enable =
					merge20(state_ff.pin_cfg.enable, WB_DAT_I, WB_SEL_I);
			end
			if (hit(WB_ADR_I, IPFC_OFS_PIN_LINE_SEL)) begin
				nxt_state.pin_cfg.line_b_sel =
					merge20(state_ff.pin_cfg.line_b_sel, WB_DAT_I, WB_SEL_I);
			end
			if (hit(WB_ADR_I, IPFC_OFS_PIN_RISE_EN)) begin
				nxt_state.pin_cfg.rise_en =
					merge20(state_ff.pin_cfg.rise_en, WB_DAT_I, WB_SEL_I);
			end
			if (hit(WB_ADR_I, IPFC_OFS_PIN_FALL_EN)) begin
				nxt_state.pin_cfg.fall_en =
					merge20(state_ff.pin_cfg.fall_en, WB_DAT_I, WB_SEL_I);
			end
		end

		if (IRQ_ENTER_I && IRQ_ENTER_SRC_I == IPFC_SRC_TIMER1) begin
			nxt_state.tpc[IPFC_TPC_T1_OVF] = 1'b0;
		end
		if (IRQ_ENTER_I && IRQ_ENTER_SRC_I == IPFC_SRC_TIMER0) begin
			nxt_state.tpc[IPFC_TPC_T0_OVF] = 1'b0;
		end

		// edge mode only reacts to a new line event
		pa_set = state_ff.tpc[IPFC_TPC_PA_TRIG] ?
			(pin_evt.line_a & ~state_ff.pa_prev) : pin_evt.line_a;
		// line b trigger select, same meaning
		pb_set = state_ff.tpc[IPFC_TPC_PB_TRIG] ?
			(pin_evt.line_b & ~state_ff.pb_prev) : pin_evt.line_b;
		nxt_state.pa_prev = pin_evt.line_a;
		nxt_state.pb_prev = pin_evt.line_b;

		// hardware sets come last so a set beats a same-cycle clear
		// line a flag set by pin event
		if (pa_set) begin
			nxt_state.tpc[IPFC_TPC_PA_FLAG] = 1'b1;
		end
		// line b flag set by pin event
		if (pb_set) begin
			nxt_state.tpc[IPFC_TPC_PB_FLAG] = 1'b1;
		end
		if (TIMER0_OVF_I) begin
			nxt_state.tpc[IPFC_TPC_T0_OVF] = 1'b1;
		end
		if (TIMER1_OVF_I) begin
			nxt_state.tpc[IPFC_TPC_T1_OVF] = 1'b1;
		end
		if (I2CM_EVT_I) begin
			nxt_state.i2cm_flag = 1'b1;
		end

		ev_set = '0;
		ev_set[IPFC_EV_PIN_A] = pa_set;
		ev_set[IPFC_EV_PIN_B] = pb_set;
		ev_set[IPFC_EV_TMR0] = TIMER0_OVF_I;
		ev_set[IPFC_EV_TMR1] = TIMER1_OVF_I;
		ev_set[IPFC_EV_I2CM] = I2CM_EVT_I;
		ev_set[IPFC_EV_WAKE] = pin_evt.wake;
		nxt_state.ev_status = (state_ff.ev_status & ~ev_clr) | ev_set;
		nxt_state.irq = |(state_ff.ev_status & state_ff.ev_enable);

		// read data is captured on the request edge, shown with ack
		if (bus_req && !state_ff.ack) begin
			nxt_state.rdata = '0;
			case ({WB_ADR_I[7:2], 2'b00})
				IPFC_OFS_TIMER_PIN_CONTROL: begin
					nxt_state.rdata[7:0] = state_ff.tpc;
				end
				IPFC_OFS_CORE_PRIORITY: begin
					nxt_state.rdata[6:0] = state_ff.core_prio;
				end
				IPFC_OFS_EXTENDED_PRIORITY: begin
					nxt_state.rdata[7:0] = state_ff.ext_prio;
				end
				IPFC_OFS_EXTENDED_FLAGS: begin
					// live mirror plus held i2c bit
					nxt_state.rdata[7:0] = (EXT_FLAG_I & IPFC_EXF_LIVE_MASK) |
						{7'h00, state_ff.i2cm_flag};
				end
				IPFC_OFS_EV_STATUS: begin
					nxt_state.rdata[IPFC_NEV-1:0] = state_ff.ev_status;
				end
				IPFC_OFS_EV_ENABLE: begin
					nxt_state.rdata[IPFC_NEV-1:0] = state_ff.ev_enable;
				end
				IPFC_OFS_PIN_ENABLE: begin
					nxt_state.rdata[IPFC_NPINS-1:0] = state_ff.pin_cfg.enable;
				end
				IPFC_OFS_PIN_LINE_SEL: begin
					nxt_state.rdata[IPFC_NPINS-1:0] = state_ff.pin_cfg.line_b_sel;
				end
				IPFC_OFS_PIN_RISE_EN: begin
					nxt_state.rdata[IPFC_NPINS-1:0] = state_ff.pin_cfg.rise_en;
				end
				IPFC_OFS_PIN_FALL_EN: begin
					nxt_state.rdata[IPFC_NPINS-1:0] = state_ff.pin_cfg.fall_en;
				end
				default: begin
					nxt_state.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign WB_DAT_O = state_ff.rdata;
	assign WB_ACK_O = state_ff.ack;
	assign TIMER1_RUN_O = state_ff.tpc[IPFC_TPC_T1_RUN];
	assign TIMER0_RUN_O = state_ff.tpc[IPFC_TPC_T0_RUN];
	assign WAKE_O = pin_evt.wake;
	assign SVC_VALID_O = grant.valid;
	assign SVC_HIGH_O = grant.high;
	assign SVC_SRC_O = grant.src;
	assign IRQ_O = state_ff.irq;

	default clocking dflt_cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);

	wb_ack_single_a: assert property ( // bus
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("ack not a single pulse one cycle after request");

	core_prio_read_a: assert property (
		WB_ACK_O && !WB_WE_I && hit(WB_ADR_I, IPFC_OFS_CORE_PRIORITY)
		|-> WB_DAT_O == {25'h0000000, state_ff.core_prio})
		else $error("core priority read mismatch");

	ext_prio_write_a: assert property (
		WB_ACK_O && WB_WE_I && WB_SEL_I[0] &&
		hit(WB_ADR_I, IPFC_OFS_EXTENDED_PRIORITY)
		|=> state_ff.ext_prio == $past(WB_DAT_I[7:0]) ##1
		prio_vec[14:7] == $past(WB_DAT_I[7:0], 2))
		else $error("extended priority not taken");

	high_first_a: assert property (
		SVC_VALID_O && !SVC_HIGH_O |-> $past((req_vec & prio_vec) == '0))
		else $error("low level granted while high level pending");

	exf_live_a: assert property (
		WB_ACK_O && !WB_WE_I && hit(WB_ADR_I, IPFC_OFS_EXTENDED_FLAGS)
		|-> WB_DAT_O[7:1] == $past(EXT_FLAG_I[7:1] & IPFC_EXF_LIVE_MASK[7:1]))
		else $error("extended flags not a live copy");

	i2cm_hold_a: assert property (
		state_ff.i2cm_flag && !(wr_now && hit(WB_ADR_I, IPFC_OFS_EXTENDED_FLAGS))
		|=> state_ff.i2cm_flag)
		else $error("i2c master flag lost without a write");

	tmr1_enter_a: assert property (
		IRQ_ENTER_I && IRQ_ENTER_SRC_I == IPFC_SRC_TIMER1 && !TIMER1_OVF_I
		|=> !state_ff.tpc[IPFC_TPC_T1_OVF])
		else $error("timer1 overflow kept after service entry");

	tmr0_enter_a: assert property (
		IRQ_ENTER_I && IRQ_ENTER_SRC_I == IPFC_SRC_TIMER0 && !TIMER0_OVF_I
		|=> !state_ff.tpc[IPFC_TPC_T0_OVF])
		else $error("timer0 overflow kept after service entry");

	pin_b_set_a: assert property (
		pin_evt.line_b && !state_ff.tpc[IPFC_TPC_PB_TRIG]
		|=> state_ff.tpc[IPFC_TPC_PB_FLAG] ##1 SVC_VALID_O)
		else $error("pin line b flag or request missing");

	pin_a_hold_a: assert property (
		state_ff.tpc[IPFC_TPC_PA_FLAG] &&
		!(wr_now && hit(WB_ADR_I, IPFC_OFS_TIMER_PIN_CONTROL))
		|=> state_ff.tpc[IPFC_TPC_PA_FLAG])
		else $error("pin line a flag dropped without software");

	irq_level_a: assert property ( // interrupt
		|(state_ff.ev_status & state_ff.ev_enable) |=> IRQ_O)
		else $error("enabled event did not raise irq");

	high_grant_c: cover property (SVC_VALID_O && SVC_HIGH_O);
	wake_seen_c: cover property (WAKE_O ##1 state_ff.ev_status[IPFC_EV_WAKE]);
	tmr1_svc_c: cover property (
		state_ff.tpc[IPFC_TPC_T1_OVF] ##1 IRQ_ENTER_I);
	wb_write_c: cover property (wr_now);
endmodule // ipfc_irq_ctrl
`default_nettype wire

// ===== verif/ipfc_periph_model.sv
// peripheral and gpio pin model standing at the far side of the irq block
`timescale 1ns/10ps
`default_nettype none
module ipfc_periph_model import ipfc_pkg::*; (
	input wire logic clk,
	input wire logic [IPFC_NPINS-1:0] pin_lvl,
	input wire logic [2:0] fire,
	input wire logic [2:0] core_lvl,
	input wire logic [7:0] ext_lvl,
	output var logic [IPFC_NPINS-1:0] pins = 20'h00000,
	output var logic t0_ovf = 1'b0,
	output var logic t1_ovf = 1'b0,
	output var logic i2cm_evt = 1'b0,
	output var logic [2:0] core_flag = 3'h0,
	output var logic [7:0] ext_flag = 8'h00
);
	// core and extended flag levels held here, watchdog among them
	// pulses last one cycle, as the timers give them
	always @(posedge clk) begin
		pins <= pin_lvl;
		{i2cm_evt, t1_ovf, t0_ovf} <= fire;
		core_flag <= core_lvl;
		ext_flag <= ext_lvl;
	end
endmodule // ipfc_periph_model
`default_nettype wire

// ===== verif/tb_irq_priority_flag_control.sv
// testbench of the irq priority and flag block
`timescale 1ns/10ps
`default_nettype none
module tb_irq_priority_flag_control import ipfc_pkg::*;;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic enter = 1'b0;
	logic [3:0] enter_src = 4'h0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [IPFC_NPINS-1:0] pin_lvl = 20'h00000;
	logic [IPFC_NPINS-1:0] pins;
	logic [2:0] fire = 3'h0;
	logic [2:0] core_lvl = 3'h0;
	logic [2:0] core_flag;
	logic [7:0] ext_lvl = 8'h00;
	logic [7:0] ext_flag;
	logic [31:0] rdat;
	logic [3:0] svc_src;
	logic ack, t0o, t1o, i2o, run0, run1, wake, svc_v, svc_h, irq;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	int wake_cnt = 0;

	ipfc_periph_model model_u (.clk(clk_sys), .pin_lvl(pin_lvl),
		.fire(fire), .core_lvl(core_lvl), .ext_lvl(ext_lvl), .pins(pins),
		.t0_ovf(t0o), .t1_ovf(t1o), .i2cm_evt(i2o), .core_flag(core_flag),
		.ext_flag(ext_flag));

	ipfc_irq_ctrl dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .GPIO_I(pins),
		.TIMER0_OVF_I(t0o), .TIMER1_OVF_I(t1o), .I2CM_EVT_I(i2o),
		.CORE_FLAG_I(core_flag), .EXT_FLAG_I(ext_flag),
		.IRQ_ENTER_I(enter), .IRQ_ENTER_SRC_I(enter_src),
		.TIMER0_RUN_O(run0), .TIMER1_RUN_O(run1), .WAKE_O(wake),
		.SVC_VALID_O(svc_v), .SVC_HIGH_O(svc_h), .SVC_SRC_O(svc_src),
		.IRQ_O(irq));

	always #20 clk_sys = ~clk_sys;

	// wake is a one-cycle pulse, so count it as it passes
	always @(posedge clk_sys) begin
		if (wake === 1'b1) begin
			wake_cnt++;
		end
	end

	task automatic close_out();
		$display("counts: %0d compared, %0d wrong", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic cmp_word(input string what, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	// request held until ack is sampled high at a rising edge
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		{cyc, stb, we} <= {2'h3, w};
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		// if ack never comes, only the hang guard ends this wait
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		cmp_word(what, e, q);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic pulse(input logic [2:0] f);
		@(posedge clk_sys);
		fire <= f;
		@(posedge clk_sys);
		fire <= 3'h0;
		tick(3);
	endtask

	task automatic svc_entry(input logic [3:0] s);
		@(posedge clk_sys);
		enter <= 1'b1;
		enter_src <= s;
		@(posedge clk_sys);
		enter <= 1'b0;
		tick(2);
	endtask

	task automatic t_reset();
		logic [7:0] ofs [9];
		ofs = '{8'h88, 8'hB8, 8'hF8, 8'hE0, 8'hC0, 8'hC8, 8'hD0, 8'hD4,
			8'hD8};
		foreach (ofs[i]) rd_chk("reset value", ofs[i], 32'h0);
		wr(8'h10, 32'hFF);
		rd_chk("unmapped", 8'h10, 32'h0);
		cmp_word("run and irq", 32'h0, {run0, run1, irq, svc_v});
		$display("test reset done");
	endtask

	task automatic t_prio();
		wr(8'hB8, 32'hFF);
		rd_chk("core_priority", 8'hB8, 32'h7F);
		wr(8'hF8, 32'hFF);
		rd_chk("extended_priority", 8'hF8, 32'hFF);
		core_lvl <= 3'h1;
		ext_lvl <= 8'h80;
		wr(8'hB8, 32'h00);
		wr(8'hF8, 32'h80);
		tick(4);
		cmp_word("grant high", 32'h1E, {svc_h, svc_src});
		wr(8'hF8, 32'h00);
		tick(4);
		cmp_word("grant natural", 32'h04, {svc_h, svc_src});
		ext_lvl <= 8'h90;
		wr(8'hF8, 32'h10);
		tick(4);
		cmp_word("grant wdt", 32'h1B, {svc_h, svc_src});
		core_lvl <= 3'h0;
		ext_lvl <= 8'h00;
		wr(8'hF8, 32'h00);
		tick(4);
		cmp_word("no grant", 32'h0, svc_v);
		$display("test priority done");
	endtask

	task automatic t_ext_flags();
		ext_lvl <= 8'hFF;
		tick(3);
		rd_chk("extended_flags", 8'hE0, 32'hEE);
		wr(8'hE0, 32'h00);
		rd_chk("flags after write", 8'hE0, 32'hEE);
		ext_lvl <= 8'h00;
		tick(3);
		rd_chk("flags dropped", 8'hE0, 32'h00);
		pulse(3'h4);
		rd_chk("i2c flag set", 8'hE0, 32'h01);
		wr(8'hE0, 32'hFF);
		rd_chk("i2c flag kept", 8'hE0, 32'h01);
		wr(8'hE0, 32'h00);
		rd_chk("i2c flag clear", 8'hE0, 32'h00);
		$display("test extended flags done");
	endtask

	task automatic t_timer();
		wr(8'h88, 32'h50);
		tick(1);
		cmp_word("timer runs", 32'h3, {run1, run0});
		pulse(3'h3);
		rd_chk("overflow flags", 8'h88, 32'hF0);
		svc_entry(IPFC_SRC_TIMER0);
		rd_chk("tmr0 entry", 8'h88, 32'hD0);
		svc_entry(IPFC_SRC_TIMER1);
		rd_chk("tmr1 entry", 8'h88, 32'h50);
		pulse(3'h3);
		wr(8'h88, 32'h50);
		rd_chk("software clear", 8'h88, 32'h50);
		wr(8'h88, 32'h00);
		tick(1);
		cmp_word("timer halt", 32'h0, {run1, run0});
		$display("test timer done");
	endtask

	task automatic t_pins();
		// sticky bits left by the earlier tests
		wr(8'hC4, 32'hFF);
		wr(8'hD0, 32'h3);
		wr(8'hD4, 32'h2);
		wr(8'hD8, 32'h1);
		wr(8'hDC, 32'h2);
		pin_lvl <= 20'h00001;
		tick(10);
		rd_chk("line a flag", 8'h88, 32'h02);
		cmp_word("wake pulses", 32'h1, wake_cnt);
		wr(8'h88, 32'h00);
		rd_chk("line a clear", 8'h88, 32'h00);
		pin_lvl <= 20'h00003;
		tick(10);
		rd_chk("rise masked", 8'h88, 32'h00);
		cmp_word("wake masked", 32'h1, wake_cnt);
		pin_lvl <= 20'h00001;
		tick(10);
		rd_chk("line b flag", 8'h88, 32'h08);
		cmp_word("wake on fall", 32'h2, wake_cnt);
		rd_chk("pin events", 8'hC0, 32'h23);
		wr(8'hC4, 32'hFF);
		wr(8'h88, 32'h00);
		rd_chk("events cleared", 8'hC0, 32'h00);
		$display("test pins done");
	endtask

	task automatic t_irq();
		wr(8'hC8, 32'h04);
		rd_chk("ev_enable", 8'hC8, 32'h04);
		pulse(3'h1);
		cmp_word("irq raised", 32'h1, irq);
		wr(8'hC4, 32'h04);
		tick(2);
		cmp_word("irq cleared", 32'h0, irq);
		wr(8'hC8, 32'h00);
		pulse(3'h1);
		cmp_word("irq masked", 32'h0, irq);
		rd_chk("sticky status", 8'hC0, 32'h04);
		$display("test interrupt done");
	endtask

	initial begin
		tick(3);
		resetn <= 1'b1;
		t_reset();
		t_prio();
		t_ext_flags();
		t_timer();
		t_pins();
		t_irq();
		close_out();
	end
endmodule // tb_irq_priority_flag_control
`default_nettype wire
